// *** rtl/upf_defines.svh ***
`ifndef UPF_DEFINES_SVH
`define UPF_DEFINES_SVH

// Data path and buffer shape
`define UPF_DATA_W            8
`define UPF_FIFO_DEPTH        16

// Clock rate and millisecond conversion
`define UPF_CLK_HZ            40000000
`define UPF_MS_PER_S          1000

// Transmit flush timeout, in milliseconds
`define UPF_TX_TIMEOUT_RST_MS 8'h10
`define UPF_TX_TIMEOUT_MIN_MS 8'h01
`define UPF_TX_TIMEOUT_MAX_MS 8'hFF

// Least wakeup pulse on the receive pin, in milliseconds
`define UPF_WAKE_MS           8'h14

`endif

// *** rtl/upf_pkg.sv ***
package upf_pkg;

  // One byte of the parallel data bus
  typedef logic [7:0] upf_byte_t;

  // Millisecond counts for flush timeout and wakeup
  typedef logic [7:0] upf_ms_t;

endpackage

// *** rtl/upf_stream_if.sv ***
`timescale 1ns/1ps
interface upf_stream_if #(
  parameter int WIDTH = 8
);
  logic             valid;  // Source holds a word
  logic             ready;  // Sink takes it this cycle
  logic [WIDTH-1:0] data;   // The word itself

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// *** rtl/upf_fifo.sv ***
`timescale 1ns/1ps
`include "upf_defines.svh"
module upf_fifo #(
  parameter int WIDTH = `UPF_DATA_W,
  parameter int DEPTH = `UPF_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Filling side
  upf_stream_if.snk inS,
  // Draining side
  upf_stream_if.src outS
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;    // Storage words
    logic [PW-1:0]               wrPtr;  // Next slot to fill
    logic [PW-1:0]               rdPtr;  // Oldest word
    logic [CW-1:0]               count;  // Words held
  } upf_fifo_st_t;

  upf_fifo_st_t st_q;
  upf_fifo_st_t st_d;
  logic         doPush;
  logic         doPop;

  // Pointer step with wrap for depths that are not powers of two
  function automatic logic [PW-1:0] nextPtr(input logic [PW-1:0] p);
    nextPtr = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction

  // Honest flags straight from the count
  assign inS.ready  = (st_q.count != CW'(DEPTH));
  assign outS.valid = (st_q.count != '0);
  assign outS.data  = st_q.mem[st_q.rdPtr];
  assign doPush     = inS.valid & inS.ready;
  assign doPop      = outS.valid & outS.ready;

  // Next state: push and pop may share a cycle
  always_comb
  begin
    st_d = st_q;
    if (doPush)
    begin
      st_d.mem[st_q.wrPtr] = inS.data;
      st_d.wrPtr           = nextPtr(st_q.wrPtr);
    end
    if (doPop)
    begin
      st_d.rdPtr = nextPtr(st_q.rdPtr);
    end
    if (doPush && !doPop)
    begin
      st_d.count = st_q.count + CW'(1);
    end
    else if (doPop && !doPush)
    begin
      st_d.count = st_q.count - CW'(1);
    end
  end

  // State register
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

endmodule // upf_fifo

// *** rtl/upf_port.sv ***
`timescale 1ns/1ps
`include "upf_defines.svh"
module upf_port #(
  parameter int DEPTH         = `UPF_FIFO_DEPTH,
  parameter int CYCLES_PER_MS = `UPF_CLK_HZ / `UPF_MS_PER_S
) (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               nrst,
  // Parallel data bus, split into in, out and enable
  input  wire upf_pkg::upf_byte_t dataIn,
  output      upf_pkg::upf_byte_t dataOut,
  output      logic               dataOe,
  // Strobes from the external logic
  input  wire logic               writeStrobe,
  input  wire logic               readStrobeN,
  // Transmit space flag pin
  output      logic               txSpaceFlagN,
  output      logic               txSpaceFlagOe,
  // Receive available flag pin, input only in suspend with remote wakeup enabled
  input  wire logic               rxAvailableFlagIn,
  output      logic               rxAvailableFlagN,
  output      logic               rxAvailableFlagOe,
  // Suspend and wakeup
  input  wire logic               usbSuspend,
  input  wire logic               remoteWakeEn,
  output      logic               powerEnableN,
  output      logic               wakeupReq,
  // Flush timeout setting
  input  wire logic               timeoutLoad,
  input  wire upf_pkg::upf_ms_t   timeoutMs,
  // Bytes towards the USB host
  output      upf_pkg::upf_byte_t usbTxData,
  output      logic               usbTxValid,
  input  wire logic               usbTxReady,
  // Bytes from the USB host
  input  wire upf_pkg::upf_byte_t usbRxData,
  input  wire logic               usbRxValid,
  output      logic               usbRxReady
);

  typedef struct packed {
    logic               wrSync1;    // Write strobe, first stage
    logic               wrSync2;    // Write strobe, second stage
    logic               wrSync3;    // Write strobe, edge history
    logic               rdSync1;    // Read strobe, first stage
    logic               rdSync2;    // Read strobe, second stage
    logic               rdSync3;    // Read strobe, edge history
    logic               pinSync1;   // Receive pin input, first stage
    logic               pinSync2;   // Receive pin input, second stage
    upf_pkg::upf_byte_t dataOut;    // Byte shown on the bus
    logic               dataOe;     // Bus driven
    logic               flagOe;     // Flags driven, low only in reset
    logic               suspended;  // Registered suspend state
    upf_pkg::upf_ms_t   timeout;    // Flush timeout in ms
    logic [31:0]        msCnt;      // Cycles within current ms
    upf_pkg::upf_ms_t   age;        // Ms since buffer became busy
    logic               flushing;   // Transmit buffer draining
    upf_pkg::upf_ms_t   wakeCnt;    // Ms the pin has been low
    logic               wakeDone;   // Resume already requested
    logic               wakeReq;    // One-cycle resume request
  } upf_port_st_t;

  upf_port_st_t st_q;
  upf_port_st_t st_d;
  logic         wrFall;
  logic         rdFall;
  logic         rdRise;
  logic         msTick;
  logic         wakeMode;

  upf_stream_if #(.WIDTH(`UPF_DATA_W)) txIn ();
  upf_stream_if #(.WIDTH(`UPF_DATA_W)) txOut ();
  upf_stream_if #(.WIDTH(`UPF_DATA_W)) rxIn ();
  upf_stream_if #(.WIDTH(`UPF_DATA_W)) rxOut ();

  // Transmit buffer: pin side fills, USB side drains
  upf_fifo #(
    .WIDTH (`UPF_DATA_W),
    .DEPTH (DEPTH)
  ) u_txFifo (
    .clk  (clk),
    .nrst (nrst),
    .inS  (txIn),
    .outS (txOut)
  );

  // Receive buffer: USB side fills, pin side drains
  upf_fifo #(
    .WIDTH (`UPF_DATA_W),
    .DEPTH (DEPTH)
  ) u_rxFifo (
    .clk  (clk),
    .nrst (nrst),
    .inS  (rxIn),
    .outS (rxOut)
  );

  // Edges only from settled stages; first stages feed nothing else
  assign wrFall   = st_q.wrSync3 & ~st_q.wrSync2;
  assign rdFall   = st_q.rdSync3 & ~st_q.rdSync2;
  assign rdRise   = ~st_q.rdSync3 & st_q.rdSync2;
  assign msTick   = (st_q.msCnt == 32'(CYCLES_PER_MS - 1));
  assign wakeMode = remoteWakeEn & st_q.suspended;

  // Byte sampled on the write strobe fall; a write while full is lost
  assign txIn.valid = wrFall;
  assign txIn.data  = dataIn;

  // USB side sees the buffer only while a flush is under way
  assign usbTxValid  = st_q.flushing & txOut.valid;
  assign usbTxData   = txOut.data;
  assign txOut.ready = st_q.flushing & usbTxReady;

  // Host bytes enter the receive buffer with back-pressure
  assign rxIn.valid = usbRxValid;
  assign rxIn.data  = usbRxData;
  assign usbRxReady = rxIn.ready;

  // Pop on the read strobe rise
  assign rxOut.ready = rdRise;

  // Flags: combinational so they follow the buffers at once
  assign txSpaceFlagN      = ~txIn.ready;
  assign txSpaceFlagOe     = st_q.flagOe;
  assign rxAvailableFlagN  = ~rxOut.valid;
  assign rxAvailableFlagOe = st_q.flagOe & ~wakeMode;

  // Registered pin outputs
  assign dataOut      = st_q.dataOut;
  assign dataOe       = st_q.dataOe;
  assign powerEnableN = st_q.suspended;
  assign wakeupReq    = st_q.wakeReq;

  // Next state
  always_comb
  begin
    st_d = st_q;

    // Synchronisers for the asynchronous strobes and the pin
    st_d.wrSync1  = writeStrobe;
    st_d.wrSync2  = st_q.wrSync1;
    st_d.wrSync3  = st_q.wrSync2;
    st_d.rdSync1  = readStrobeN;
    st_d.rdSync2  = st_q.rdSync1;
    st_d.rdSync3  = st_q.rdSync2;
    st_d.pinSync1 = rxAvailableFlagIn;
    st_d.pinSync2 = st_q.pinSync1;

    // Flags leave high impedance on the first edge after reset
    st_d.flagOe    = 1'b1;
    st_d.suspended = usbSuspend;

    // Read bus: drive head byte while strobe low, release on rise
    if (rdFall)
    begin
      st_d.dataOe  = 1'b1;
      st_d.dataOut = rxOut.data;
    end
    else if (rdRise)
    begin
      st_d.dataOe = 1'b0;
    end

    // Free-running millisecond base
    st_d.msCnt = msTick ? '0 : st_q.msCnt + 32'h0000_0001;

    // Settings below the least legal value are ignored
    if (timeoutLoad && (timeoutMs >= `UPF_TX_TIMEOUT_MIN_MS) && (timeoutMs <= `UPF_TX_TIMEOUT_MAX_MS))
    begin
      st_d.timeout = timeoutMs;
    end

    // Flush when the age reaches the timeout or the buffer fills;
    // the age starts mid-millisecond, so flushes come early, never late
    if (!txOut.valid)
    begin
      st_d.age      = '0;
      st_d.flushing = 1'b0;
    end
    else if (!st_q.flushing)
    begin
      if (!txIn.ready)
      begin
        st_d.flushing = 1'b1;
      end
      else if (msTick)
      begin
        st_d.age = st_q.age + 8'h01;
        if (({1'b0, st_q.age} + 9'h001) >= {1'b0, st_q.timeout})
        begin
          st_d.flushing = 1'b1;
        end
      end
    end

    // Wakeup: pin held low for a full window gives one request;
    // one extra tick covers the partial first millisecond
    st_d.wakeReq = 1'b0;
    if (!wakeMode || st_q.pinSync2)
    begin
      st_d.wakeCnt  = '0;
      st_d.wakeDone = 1'b0;
    end
    else if (!st_q.wakeDone && msTick)
    begin
      if (st_q.wakeCnt == `UPF_WAKE_MS)
      begin
        st_d.wakeReq  = 1'b1;
        st_d.wakeDone = 1'b1;
      end
      else
      begin
        st_d.wakeCnt = st_q.wakeCnt + 8'h01;
      end
    end
  end

  // State register; strobes reset to their idle level
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_q         <= '0;
      st_q.wrSync1 <= 1'b1;
      st_q.wrSync2 <= 1'b1;
      st_q.wrSync3 <= 1'b1;
      st_q.rdSync1 <= 1'b1;
      st_q.rdSync2 <= 1'b1;
      st_q.rdSync3 <= 1'b1;
      // Pin idles high, so a suspend right after reset sees no false low
      st_q.pinSync1 <= 1'b1;
      st_q.pinSync2 <= 1'b1;
      st_q.timeout <= `UPF_TX_TIMEOUT_RST_MS;
    end
    else
    begin
      st_q <= st_d;
    end
  end

endmodule // upf_port

// *** tb/upf_port_assertions.sv ***
`timescale 1ns/1ps
module upf_port_assertions (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Parallel side
  input wire logic readStrobeN,
  input wire logic dataOe,
  input wire logic txSpaceFlagN,
  input wire logic txSpaceFlagOe,
  input wire logic rxAvailableFlagN,
  input wire logic rxAvailableFlagOe,
  input wire logic rxAvailableFlagIn,
  // USB side and suspend
  input wire logic usbTxValid,
  input wire logic usbTxReady,
  input wire logic usbRxValid,
  input wire logic usbRxReady,
  input wire logic remoteWakeEn,
  input wire logic powerEnableN,
  input wire logic wakeupReq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // Reset itself is the cause here, so this one is never disabled
  chk_reset_float: assert property (disable iff (1'b0) !nrst |-> !txSpaceFlagOe && !rxAvailableFlagOe)
    else $error("flag driven in reset");
  chk_read_drive: assert property ($fell(readStrobeN) |-> ##[2:5] dataOe)
    else $error("bus idle on read");
  chk_read_release: assert property ($rose(readStrobeN) |-> ##[1:6] !dataOe)
    else $error("bus held after read");
  chk_rx_flag_set: assert property (usbRxValid && usbRxReady |=> !rxAvailableFlagN)
    else $error("receive flag high with data");
  chk_wake_input: assert property (remoteWakeEn && powerEnableN |-> !rxAvailableFlagOe)
    else $error("receive pin driven in suspend");
  chk_tx_hold: assert property (usbTxValid && !usbTxReady |=> usbTxValid)
    else $error("flush dropped");
  chk_wake_pulse: assert property (wakeupReq |=> !wakeupReq)
    else $error("resume request too long");
  chk_wake_cause: assert property (wakeupReq |-> powerEnableN && !$past(rxAvailableFlagIn, 3))
    else $error("resume without low pin");

  // Main scenarios reached
  cover property (usbTxValid && usbTxReady);
  cover property (txSpaceFlagOe && txSpaceFlagN);
  cover property (wakeupReq);
endmodule // upf_port_assertions

bind upf_port upf_port_assertions chk (.clk, .nrst, .readStrobeN, .dataOe, .txSpaceFlagN, .txSpaceFlagOe,
  .rxAvailableFlagN, .rxAvailableFlagOe, .rxAvailableFlagIn, .usbTxValid, .usbTxReady,
  .usbRxValid, .usbRxReady, .remoteWakeEn, .powerEnableN, .wakeupReq);

// *** tb/upf_ext_model.sv ***
`timescale 1ns/1ps
module upf_ext_model (
  // Clock
  input  wire logic               clk,
  // Pins driven by the external logic
  output      upf_pkg::upf_byte_t dataIn,
  output      logic               writeStrobe,
  output      logic               readStrobeN,
  output      logic               wakeN,
  // Bus driven by the port
  input  wire upf_pkg::upf_byte_t dataOut,
  input  wire logic               dataOe
);
  // Strobes idle high, so leaving reset shows no edge
  initial
  begin
    dataIn      = 8'h00;
    writeStrobe = 1'b1;
    readStrobeN = 1'b1;
    wakeN       = 1'b1;
  end

  // Byte held 5 clocks, as the port samples it late
  task automatic wr(input upf_pkg::upf_byte_t b);
    dataIn      = b;
    writeStrobe = 1'b0;
    repeat (5) @(negedge clk);
    writeStrobe = 1'b1;
    dataIn      = ~b; // Released bus changes value
    repeat (4) @(negedge clk);
  endtask

  // Returns what the bus held and whether it was driven
  task automatic rd(output upf_pkg::upf_byte_t b, output logic oe);
    readStrobeN = 1'b0;
    repeat (6) @(negedge clk);
    b           = dataOut;
    oe          = dataOe;
    readStrobeN = 1'b1;
    repeat (6) @(negedge clk);
  endtask

  // Holds the receive pin low to ask for a resume
  task automatic wake(input int cyc);
    wakeN = 1'b0;
    repeat (cyc) @(negedge clk);
    wakeN = 1'b1;
  endtask
endmodule // upf_ext_model

// *** tb/test_upf_port.sv ***
`timescale 1ns/1ps
module test_upf_port;
  localparam int MS = 10; // Short millisecond keeps runs brief
  logic               clk = 1'b0;
  logic               nrst = 1'b1; // Pulled low just after time zero so the reset edge is seen
  upf_pkg::upf_byte_t dataIn, dataOut, usbTxData, rdByte;
  upf_pkg::upf_byte_t usbRxData = 8'h00;
  upf_pkg::upf_ms_t   timeoutMs = 8'h00;
  logic               dataOe, writeStrobe, readStrobeN, txSpaceFlagN, txSpaceFlagOe, rdOe;
  logic               rxAvailableFlagN, rxAvailableFlagOe, wakeN, powerEnableN, wakeupReq;
  logic               usbSuspend = 1'b0, remoteWakeEn = 1'b0, timeoutLoad = 1'b0;
  logic               usbTxValid, usbRxReady, usbTxReady = 1'b0, usbRxValid = 1'b0;
  int                 errTotal = 0, cmpCount = 0, n;
  upf_pkg::upf_byte_t rxVals [3] = '{8'hA5, 8'h00, 8'hFF};
  int                 msSet [3] = '{1, 0, 255}; // Zero is ignored
  int                 msExp [3] = '{1, 1, 255};
  wire                rxPin = rxAvailableFlagOe ? rxAvailableFlagN : wakeN; // Pin seen from both ends

  upf_port #(.CYCLES_PER_MS(MS)) dut (.clk, .nrst, .dataIn, .dataOut, .dataOe, .writeStrobe,
    .readStrobeN, .txSpaceFlagN, .txSpaceFlagOe, .rxAvailableFlagIn(rxPin), .rxAvailableFlagN,
    .rxAvailableFlagOe, .usbSuspend, .remoteWakeEn, .powerEnableN, .wakeupReq, .timeoutLoad,
    .timeoutMs, .usbTxData, .usbTxValid, .usbTxReady, .usbRxData, .usbRxValid, .usbRxReady);
  upf_ext_model ext (.clk, .dataIn, .writeStrobe, .readStrobeN, .wakeN, .dataOut, .dataOe);

  always #12.5 clk = ~clk;

  task automatic giveVerdict;
    $display("checks %0d mismatches %0d", cmpCount, errTotal);
    if (errTotal == 0 && cmpCount > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
    cmpCount++;
    if (seen !== exp)
    begin
      errTotal++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // A wait that runs out ends the run
  task automatic waitFor(ref logic sig, input int lim);
    n = 0;
    while (sig !== 1'b1 && n < lim)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= lim)
    begin
      errTotal++;
      $display("mismatch wait expected below %0d seen %0d", lim, n);
      giveVerdict();
    end
  endtask

  // Write one byte and time its way to the host, counted from the strobe fall;
  // the host stalls so a short timeout cannot drain the byte unseen
  task automatic flushOne(input upf_pkg::upf_byte_t b, input int ms);
    usbTxReady = 1'b0;
    fork
      ext.wr(b);
      waitFor(usbTxValid, ms * MS + 50);
    join
    check("tx byte", usbTxData, b);
    check("tx delay", n >= (ms - 1) * MS && n <= ms * MS + 4, 1);
    usbTxReady = 1'b1;
    @(negedge clk);
    usbTxReady = 1'b0;
    @(negedge clk);
  endtask

  task automatic testReset;
    #1 nrst = 1'b0;
    repeat (5) @(negedge clk);
    check("oe in reset", {dataOe, txSpaceFlagOe, rxAvailableFlagOe}, 0);
    nrst = 1'b1;
    repeat (3) @(negedge clk);
    check("flags", {txSpaceFlagOe, rxAvailableFlagOe, txSpaceFlagN, rxAvailableFlagN}, 4'b1101);
    $display("test reset done");
  endtask

  // Host bytes come out in order, one per read strobe
  task automatic testRead;
    for (int i = 0; i < 3; i++)
    begin
      usbRxData  = rxVals[i];
      usbRxValid = 1'b1;
      @(negedge clk);
    end
    usbRxValid = 1'b0;
    @(negedge clk);
    check("rx flag", rxAvailableFlagN, 0);
    for (int i = 0; i < 3; i++)
    begin
      ext.rd(rdByte, rdOe);
      check("read", {rdOe, rdByte}, {1'b1, rxVals[i]});
      check("released", dataOe, 0);
      check("rx flag", rxAvailableFlagN, i == 2);
    end
    $display("test read done");
  endtask

  // Default timeout first, then loaded ones
  task automatic testFlush;
    flushOne(8'h3C, 16);
    for (int i = 0; i < 3; i++)
    begin
      timeoutMs   = 8'(msSet[i]);
      timeoutLoad = 1'b1;
      @(negedge clk);
      timeoutLoad = 1'b0;
      flushOne(8'hC3 ^ 8'(i), msExp[i]);
    end
    $display("test flush done");
  endtask

  // Fill against a stalled host, then drain in order
  task automatic testFill;
    usbTxReady = 1'b0;
    for (int i = 0; i < 16; i++)
    begin
      check("space", txSpaceFlagN, 0);
      ext.wr(8'h80 + 8'(i));
    end
    check("full", {txSpaceFlagN, usbTxValid}, 2'b11);
    usbTxReady = 1'b1;
    for (int i = 0; i < 16; i++)
    begin
      check("drain", {usbTxValid, usbTxData}, {1'b1, 8'h80 + 8'(i)});
      @(negedge clk);
    end
    usbTxReady = 1'b0;
    check("drained", {usbTxValid, txSpaceFlagN}, 0);
    $display("test fill done");
  endtask

  // Suspend turns the pin to input; a long low asks for resume
  task automatic testWake;
    usbSuspend   = 1'b1;
    remoteWakeEn = 1'b1;
    repeat (3) @(negedge clk);
    check("suspend", {powerEnableN, rxAvailableFlagOe}, 2'b10);
    fork
      ext.wake(25 * MS);
      waitFor(wakeupReq, 25 * MS);
    join
    check("wake time", n >= 20 * MS - 2 && n <= 21 * MS + 5, 1);
    usbSuspend   = 1'b0;
    remoteWakeEn = 1'b0;
    repeat (3) @(negedge clk);
    check("awake", rxAvailableFlagOe, 1);
    $display("test wake done");
  endtask

  initial
  begin
    testReset();
    testRead();
    testFlush();
    testFill();
    testWake();
    giveVerdict();
  end
endmodule // test_upf_port
